// [mul_busy_counter.sv]
// Down-counter of remaining multiplier busy cycles
`timescale 1ns/10ps
`default_nettype none

module mul_busy_counter (
    input wire logic core_clk_i,
    input wire logic reset_i,
    mul_busy_if.counter busy_if
);
    import mul_interlock_pkg::*;

    logic [BUSY_W-1:0] count_q;
    logic [BUSY_W-1:0] count_d;

    // ==========================================================
    // Next count
    // ==========================================================
    // A load restarts the count no matter how much was left
    always_comb begin
        if (busy_if.load) begin
            count_d = busy_if.load_value;
        end else if (count_q != BUSY_ZERO) begin
            count_d = count_q - 3'h1;
        end else begin
            count_d = BUSY_ZERO;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            count_q <= RESET_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    assign busy_if.count = count_q;
    assign busy_if.count_next = count_d;

endmodule : mul_busy_counter

`default_nettype wire

// [mul_busy_if.sv]
// Interface between the interlock and its multiplier busy counter
`timescale 1ns/10ps
`default_nettype none

interface mul_busy_if;
    import mul_interlock_pkg::*;
    logic load;
    logic [BUSY_W-1:0] load_value;
    logic [BUSY_W-1:0] count;
    logic [BUSY_W-1:0] count_next;

    modport ctrl (output load, output load_value, input count, input count_next);
    modport counter (input load, input load_value, output count, output count_next);
endinterface : mul_busy_if

`default_nettype wire

// [mul_interlock_pkg.sv]
// Shared constants and types for the multiplier contention interlock
package mul_interlock_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CORE_CLK_PERIOD_PS = 5000;
    localparam int BUSY_W = 3;
    localparam logic [BUSY_W-1:0] BUSY_ZERO = 3'h0;
    // Multiplier busy time after the operand access, in core cycles
    localparam logic [BUSY_W-1:0] DOUBLE_MAC_BUSY_CYCLES = 3'h4;
    localparam logic [BUSY_W-1:0] WORD_MAC_BUSY_CYCLES = 3'h2;
    localparam logic [BUSY_W-1:0] OTHER_MUL_BUSY_CYCLES = 3'h4;
    localparam int DECODE_HOLD_SLOTS = 1;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic RESET_FLAG = 1'b0;
    localparam logic [BUSY_W-1:0] RESET_COUNT = 3'h0;

    // ==========================================================
    // Instruction classes seen by the interlock, and its memory access states
    // ==========================================================
    typedef enum logic [1:0] {
        CLASS_NONE,
        CLASS_DOUBLE_MAC,
        CLASS_WORD_MAC,
        CLASS_OTHER_MUL
    } mul_class_t;

    typedef enum logic [1:0] {
        MA_IDLE,
        MA_STRETCH,
        MA_RUN
    } ma_state_t;

endpackage : mul_interlock_pkg

// [multiplier_contention_interlock.sv]
// Multiplier contention interlock between decode, memory access and the shared multiplier
//
// Behaviour
// RULE1: stretch follower operand access while multiplier busy
// RULE2: enough intervening instructions cause no stall
// RULE3: memory access still wins over fetch, splitting slot
// RULE4: stall length taken from live busy count
// RULE5: double accumulate: two accesses, second feeds multiplier
// RULE6: multiplier busy four cycles after final access, two for a word MAC
// RULE7: hold decode one slot after double accumulate
// RULE8: busy down-counter holds waiting multiplier users
`timescale 1ns/10ps
`default_nettype none

module multiplier_contention_interlock (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic decode_advance_i,
    input wire mul_interlock_pkg::mul_class_t decode_class_i,
    input wire logic ma_req_i,
    input wire logic ma_operand_i,
    input wire mul_interlock_pkg::mul_class_t ma_class_i,
    input wire logic fetch_req_i,
    output logic decode_hold_o,
    output logic execute_hold_o,
    output logic ma_stretch_o,
    output logic ma_done_o,
    output logic fetch_grant_o,
    output logic fetch_split_o,
    output logic mul_start_o,
    output mul_interlock_pkg::mul_class_t mul_class_o,
    output logic mul_busy_o,
    output logic [mul_interlock_pkg::BUSY_W-1:0] busy_count_o
);
    import mul_interlock_pkg::*;

    mul_busy_if busy_if ();

    mul_busy_counter u_busy_counter (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .busy_if(busy_if)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic uses_multiplier(input mul_class_t cls);
        uses_multiplier = (cls != CLASS_NONE);
    endfunction : uses_multiplier

    function automatic logic [BUSY_W-1:0] busy_length(input mul_class_t cls);
        case (cls)
            CLASS_DOUBLE_MAC: busy_length = DOUBLE_MAC_BUSY_CYCLES;
            CLASS_WORD_MAC: busy_length = WORD_MAC_BUSY_CYCLES;
            CLASS_OTHER_MUL: busy_length = OTHER_MUL_BUSY_CYCLES;
            default: busy_length = BUSY_ZERO;
        endcase
    endfunction : busy_length

    // ==========================================================
    // State
    // ==========================================================
    ma_state_t ma_next;
    logic ma_stretch_q;
    logic ma_stretch_d;
    logic decode_hold_q;
    logic decode_hold_d;
    logic execute_hold_q;
    logic execute_hold_d;
    logic ma_done_q;
    logic ma_done_d;
    logic fetch_grant_q;
    logic fetch_grant_d;
    logic fetch_split_q;
    logic fetch_split_d;
    logic mul_start_q;
    logic mul_start_d;
    mul_class_t mul_class_q;
    mul_class_t mul_class_d;
    logic mul_busy_q;
    logic mul_busy_d;
    logic [BUSY_W-1:0] busy_count_q;
    logic [BUSY_W-1:0] busy_count_d;
    logic operand_wait;
    logic busy_next_cycle;

    // ==========================================================
    // Stall condition
    // ==========================================================
    // Requests announce the slot that follows; every decision below
    // is about that slot so that all outputs can leave a flip-flop.
    // Busy in the next cycle comes from the live count, so a
    // follower that was already delayed by fetch waits less.
    always_comb begin
        busy_next_cycle = (busy_if.count_next != BUSY_ZERO); // see RULE4
        operand_wait = ma_req_i && ma_operand_i && uses_multiplier(ma_class_i)
            && busy_next_cycle; // see RULE8
    end

    // ==========================================================
    // Busy counter load
    // ==========================================================
    // The count starts once the final access has ended; kept apart from
    // the stall logic, which reads the counter's next value.
    always_comb begin
        busy_if.load = mul_start_q; // see RULE6
        busy_if.load_value = busy_length(mul_class_q); // see RULE6
    end

    // ==========================================================
    // Memory access stage
    // ==========================================================
    always_comb begin
        ma_next = MA_IDLE;
        ma_done_d = RESET_FLAG;
        if (ma_req_i) begin
            if (operand_wait) begin
                // One long bus cycle, not repeated accesses
                ma_next = MA_STRETCH; // see RULE1
            end else begin
                // With the multiplier idle by now nothing is stalled
                ma_next = MA_RUN; // see RULE2
                ma_done_d = 1'b1;
            end
        end
        case (ma_next)
            MA_STRETCH: ma_stretch_d = 1'b1; // see RULE1
            MA_RUN: ma_stretch_d = 1'b0;
            MA_IDLE: ma_stretch_d = 1'b0;
            default: ma_stretch_d = 1'b0;
        endcase
        execute_hold_d = operand_wait; // see RULE8
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ma_stretch_q <= RESET_FLAG;
            ma_done_q <= RESET_FLAG;
            execute_hold_q <= RESET_FLAG;
        end else begin
            ma_stretch_q <= ma_stretch_d;
            ma_done_q <= ma_done_d;
            execute_hold_q <= execute_hold_d;
        end
    end

    // ==========================================================
    // Multiplier hand-off
    // ==========================================================
    always_comb begin
        mul_start_d = RESET_FLAG;
        mul_class_d = mul_class_q;
        if (ma_req_i && ma_operand_i && uses_multiplier(ma_class_i) && !operand_wait) begin
            // Only the operand access hands work to the multiplier
            mul_start_d = 1'b1; // see RULE5
            mul_class_d = ma_class_i;
        end
        mul_busy_d = busy_next_cycle; // see RULE8
        busy_count_d = busy_if.count_next;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            mul_start_q <= RESET_FLAG;
            mul_class_q <= CLASS_NONE;
            mul_busy_q <= RESET_FLAG;
            busy_count_q <= RESET_COUNT;
        end else begin
            mul_start_q <= mul_start_d;
            mul_class_q <= mul_class_d;
            mul_busy_q <= mul_busy_d;
            busy_count_q <= busy_count_d;
        end
    end

    // ==========================================================
    // Bus sharing with fetch
    // ==========================================================
    // A stretched access keeps the bus, so fetch goes after it
    always_comb begin
        fetch_grant_d = fetch_req_i && !ma_req_i; // see RULE3
        fetch_split_d = fetch_req_i && ma_req_i; // see RULE3
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            fetch_grant_q <= RESET_FLAG;
            fetch_split_q <= RESET_FLAG;
        end else begin
            fetch_grant_q <= fetch_grant_d;
            fetch_split_q <= fetch_split_d;
        end
    end

    // ==========================================================
    // Decode hold
    // ==========================================================
    // A second double accumulate during the hold does not extend it
    always_comb begin
        decode_hold_d = decode_advance_i && (decode_class_i == CLASS_DOUBLE_MAC)
            && !decode_hold_q; // see RULE7
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            decode_hold_q <= RESET_FLAG;
        end else begin
            decode_hold_q <= decode_hold_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign ma_stretch_o = ma_stretch_q;
    assign decode_hold_o = decode_hold_q;
    assign execute_hold_o = execute_hold_q;
    assign ma_done_o = ma_done_q;
    assign fetch_grant_o = fetch_grant_q;
    assign fetch_split_o = fetch_split_q;
    assign mul_start_o = mul_start_q;
    assign mul_class_o = mul_class_q;
    assign mul_busy_o = mul_busy_q;
    assign busy_count_o = busy_count_q;

endmodule : multiplier_contention_interlock

`default_nettype wire

// [multiplier_contention_interlock_asserts.sv]
// Port checks for the multiplier contention interlock
`timescale 1ns/10ps
`default_nettype none
module multiplier_contention_interlock_asserts (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic decode_advance_i,
    input wire mul_interlock_pkg::mul_class_t decode_class_i,
    input wire logic ma_req_i,
    input wire logic ma_operand_i,
    input wire mul_interlock_pkg::mul_class_t ma_class_i,
    input wire logic fetch_req_i,
    input wire logic decode_hold_o,
    input wire logic execute_hold_o,
    input wire logic ma_stretch_o,
    input wire logic ma_done_o,
    input wire logic fetch_grant_o,
    input wire logic fetch_split_o,
    input wire logic mul_start_o,
    input wire mul_interlock_pkg::mul_class_t mul_class_o,
    input wire logic mul_busy_o,
    input wire logic [mul_interlock_pkg::BUSY_W-1:0] busy_count_o
);
    import mul_interlock_pkg::*;
    logic op_w;
    assign op_w = ma_req_i && ma_operand_i && ma_class_i != CLASS_NONE;
    // ==========
    // Properties
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_drain;
        busy_count_o == 3'h4 ##1 busy_count_o == 3'h3 ##1 busy_count_o == 3'h2 ##1 busy_count_o == 3'h1 ##1 !mul_busy_o;
    endsequence
    sequence s_hold_one;
        decode_hold_o ##1 !decode_hold_o;
    endsequence
    property p_start; op_w && ma_class_i == CLASS_DOUBLE_MAC && busy_count_o == BUSY_ZERO && !mul_start_o
        |=> mul_start_o && mul_class_o == CLASS_DOUBLE_MAC; endproperty
    property p_drain; mul_start_o && mul_class_o == CLASS_DOUBLE_MAC |=> s_drain; endproperty
    // A start in the current cycle loads the counter, so the next operand still waits
    property p_hold; op_w && (busy_count_o > 3'h1 || mul_start_o) |=> ma_stretch_o && !mul_start_o; endproperty
    property p_free; op_w && busy_count_o <= 3'h1 && !mul_start_o |=> ma_done_o && !ma_stretch_o; endproperty
    property p_stall; ma_stretch_o |-> execute_hold_o && !ma_done_o && mul_busy_o; endproperty
    property p_decode; decode_advance_i && decode_class_i == CLASS_DOUBLE_MAC && !decode_hold_o |=> s_hold_one; endproperty
    property p_split; ma_req_i && fetch_req_i |=> fetch_split_o && !fetch_grant_o; endproperty
    property p_busy; mul_busy_o == (busy_count_o != BUSY_ZERO); endproperty
    a_start: assert property (p_start) else $error("operand access did not start multiplier");
    a_drain: assert property (p_drain) else $error("busy count did not run four cycles");
    a_hold: assert property (p_hold) else $error("operand access not stretched");
    a_free: assert property (p_free) else $error("stall with multiplier free");
    a_stall: assert property (p_stall) else $error("stretch without busy multiplier");
    a_decode: assert property (p_decode) else $error("decode hold not one cycle");
    a_split: assert property (p_split) else $error("fetch not split");
    a_busy: assert property (p_busy) else $error("busy flag disagrees with counter");
endmodule : multiplier_contention_interlock_asserts
`default_nettype wire

// [multiplier_contention_interlock_tb_top.sv]
// Self-checking bench for the multiplier contention interlock
`timescale 1ns/10ps
`default_nettype none
module multiplier_contention_interlock_tb_top;
    import mul_interlock_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic decode_advance_i = 1'b0;
    mul_class_t decode_class_i = CLASS_NONE;
    logic ma_req_i = 1'b0;
    logic ma_operand_i = 1'b0;
    mul_class_t ma_class_i = CLASS_NONE;
    logic fetch_req_i = 1'b0;
    logic decode_hold_o, execute_hold_o, ma_stretch_o, ma_done_o;
    logic fetch_grant_o, fetch_split_o, mul_start_o, mul_busy_o;
    mul_class_t mul_class_o;
    logic [BUSY_W-1:0] busy_count_o;
    int err_count = 0;
    int total_checks = 0;
    multiplier_contention_interlock u_multiplier_contention_interlock (.*);
    initial forever #2.5 core_clk_i = ~core_clk_i;
    // ==========
    // Checking and ending
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // ==========
    // Scenarios
    // Re-presents the access each stretched cycle and counts the stretch
    task automatic access(input mul_class_t c, input logic op, input int n);
        int s;
        s = 0;
        ma_req_i = 1'b1;
        ma_operand_i = op;
        ma_class_i = c;
        for (int k = 0; k < 8; k++) begin
            @(negedge core_clk_i);
            chk(fetch_split_o, fetch_req_i);
            if (ma_done_o === 1'b1) break;
            chk(ma_stretch_o && execute_hold_o, 1'b1);
            s++;
        end
        chk(ma_done_o, 1'b1);
        ma_req_i = 1'b0;
        chk(mul_start_o, op);
        if (op) chk(mul_class_o, c);
        chk(8'(s), 8'(n));
    endtask : access
    task automatic t_decode;
        decode_advance_i = 1'b1;
        decode_class_i = CLASS_DOUBLE_MAC;
        @(negedge core_clk_i);
        decode_advance_i = 1'b0;
        chk(decode_hold_o, 1'b1);
        @(negedge core_clk_i);
        chk(decode_hold_o, 1'b0);
        $display("decode hold test done");
    endtask : t_decode
    task automatic t_drain;
        access(CLASS_DOUBLE_MAC, 1'b0, 0);
        @(negedge core_clk_i);
        access(CLASS_DOUBLE_MAC, 1'b1, 0);
        for (int k = int'(DOUBLE_MAC_BUSY_CYCLES); k >= 0; k--) begin
            @(negedge core_clk_i);
            chk(busy_count_o, 8'(k));
            chk(mul_busy_o, k != 0);
        end
        $display("drain test done");
    endtask : t_drain
    // Word access after a double one, with a growing gap and fetch always pending
    task automatic t_gap;
        fetch_req_i = 1'b1;
        for (int g = 0; g < 4; g++) begin
            access(CLASS_DOUBLE_MAC, 1'b1, 0);
            repeat (g + 1) @(negedge core_clk_i);
            access(CLASS_WORD_MAC, 1'b1, g < 3 ? 3 - g : 0);
            @(negedge core_clk_i);
            chk(busy_count_o, WORD_MAC_BUSY_CYCLES);
            chk(fetch_grant_o, 1'b1);
            repeat (3) @(negedge core_clk_i);
        end
        fetch_req_i = 1'b0;
        $display("gap test done");
    endtask : t_gap
    // Mid-run reset while the multiplier is busy, using the other multiply class
    task automatic t_reset;
        access(CLASS_OTHER_MUL, 1'b1, 0);
        @(negedge core_clk_i);
        chk(busy_count_o, OTHER_MUL_BUSY_CYCLES);
        reset_i = 1'b1;
        @(negedge core_clk_i);
        reset_i = 1'b0;
        chk(busy_count_o, BUSY_ZERO);
        chk(mul_busy_o, 1'b0);
        chk(mul_class_o, CLASS_NONE);
        access(CLASS_WORD_MAC, 1'b1, 0);
        $display("reset test done");
    endtask : t_reset
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge core_clk_i);
        reset_i = 1'b0;
        @(negedge core_clk_i);
        chk(busy_count_o, 8'h00);
        chk(mul_class_o, CLASS_NONE);
        t_decode();
        t_drain();
        t_gap();
        t_reset();
        summarize();
    end
endmodule : multiplier_contention_interlock_tb_top
bind multiplier_contention_interlock multiplier_contention_interlock_asserts
    u_multiplier_contention_interlock_asserts (.*);
`default_nettype wire
